// ===== hw/gpp_pkg.sv
// Purpose: shared constants and types of the general purpose pin port
// Assumes: one peripheral clock, 32-bit register port with byte addresses
// Notes: every address below is a full byte address of one aligned word
package gpp_pkg;

  localparam int PIN_COUNT = 16;

  typedef logic [15:0] gpp_pins_t;

  // register addresses
  localparam logic [31:0] ADDR_ENABLE = 32'h01B0_0000;
  localparam logic [31:0] ADDR_DIRECTION = 32'h01B0_0004;
  localparam logic [31:0] ADDR_VALUE = 32'h01B0_0008;
  localparam logic [31:0] ADDR_RESERVED = 32'h01B0_000C;
  localparam logic [31:0] ADDR_RISE_FLAGS = 32'h01B0_0010;
  localparam logic [31:0] ADDR_RISE_MASK = 32'h01B0_0014;
  localparam logic [31:0] ADDR_FALL_FLAGS = 32'h01B0_0018;
  localparam logic [31:0] ADDR_FALL_MASK = 32'h01B0_001C;
  localparam logic [31:0] ADDR_GLOBAL_CTRL = 32'h01B0_0020;
  localparam logic [31:0] ADDR_POLARITY = 32'h01B0_0024;

  // field positions
  localparam int GC_MODE_LSB = 0;

  // values after reset
  localparam gpp_pins_t RST_ENABLE = 16'h0000;
  localparam gpp_pins_t RST_DIRECTION = 16'h0000;
  localparam gpp_pins_t RST_VALUE = 16'h0000;
  localparam gpp_pins_t RST_FLAGS = 16'h0000;
  localparam gpp_pins_t RST_MASK = 16'h0000;
  localparam gpp_pins_t RST_POLARITY = 16'h0000;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // event generation modes
  typedef enum logic [1:0] {
    GPP_MODE_OFF = 2'b00,
    GPP_MODE_ANY = 2'b01,
    GPP_MODE_ALL = 2'b10,
    GPP_MODE_LEVEL = 2'b11
  } gpp_mode_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpp_bus_req_t;

  typedef struct packed {
    gpp_pins_t level;
    gpp_pins_t oe_n;
    gpp_pins_t owned;
  } gpp_pad_t;

  typedef struct packed {
    logic cpu_interrupt;
    logic dma_event_request;
  } gpp_event_t;

  typedef struct packed {
    gpp_pins_t enable;
    gpp_pins_t direction;
    gpp_pins_t value;
    gpp_pins_t rise_flags;
    gpp_pins_t rise_mask;
    gpp_pins_t fall_flags;
    gpp_pins_t fall_mask;
    gpp_pins_t polarity;
    gpp_mode_t mode;
    gpp_pins_t sync1;
    gpp_pins_t sync2;
    gpp_pins_t prev;
    logic [31:0] rdata;
    logic event_lvl;
    logic dma_pulse;
  } gpp_state_t;

  localparam gpp_state_t RST_STATE = '{
    enable: RST_ENABLE,
    direction: RST_DIRECTION,
    value: RST_VALUE,
    rise_flags: RST_FLAGS,
    rise_mask: RST_MASK,
    fall_flags: RST_FLAGS,
    fall_mask: RST_MASK,
    polarity: RST_POLARITY,
    mode: GPP_MODE_OFF,
    sync1: 16'h0000,
    sync2: 16'h0000,
    prev: 16'h0000,
    rdata: RDATA_IDLE,
    event_lvl: 1'b0,
    dma_pulse: 1'b0
  };

endpackage : gpp_pkg

// ===== hw/gpp_port.sv
// Purpose: sixteen pin general purpose port with edge detect and events
// Assumes: pins asynchronous inputs, registers on a plain strobe port
// Notes: read data valid in the cycle after the read strobe only
`timescale 1ns/1ps

// Contract
// - The port has sixteen pins, 15 down to 0, each usable as input or output.
// - A pin is under port control only while its enable bit is 1.
// - An enabled pin with direction bit 0 is an input and is not driven.
// - An enabled pin with direction bit 1 is an output and is driven.
// - The direction bit has effect only when the enable bit of that pin is set.
// - After reset all direction bits select input.
// - An output pin drives the value software wrote into the value register.
// - Reading the value register returns the present level of each input pin.
// - Pin activity raises a processor interrupt and a DMA event in selectable modes.
// - Enable, direction and value sit at consecutive words from the base, then a reserved word.
// - A rise detect register and its mask select which pins raise events on a rising edge.
// - A fall detect register and its mask select which pins raise events on a falling edge.
// - A global control register after the fall mask selects the event mode.
// - A polarity register selects per pin which level or edge counts as active.
module gpp_port (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire gpp_pkg::gpp_bus_req_t i_bus,
  output logic [31:0] o_rdata,
  input wire gpp_pkg::gpp_pins_t i_pin_in,
  output gpp_pkg::gpp_pad_t o_pad,
  output gpp_pkg::gpp_event_t o_evt
);
  import gpp_pkg::*;

  gpp_state_t st;
  gpp_state_t nx;

  gpp_pins_t sense;
  gpp_pins_t watch;
  gpp_pins_t drive;
  gpp_pins_t rise_hit;
  gpp_pins_t fall_hit;
  gpp_pins_t masked;
  gpp_pins_t selected;
  gpp_pins_t value_view;
  logic ev_any;
  logic ev_all;
  logic ev_level;
  logic ev_next;

  logic wr_enable;
  logic wr_direction;
  logic wr_value;
  logic wr_rise_flags;
  logic wr_rise_mask;
  logic wr_fall_flags;
  logic wr_fall_mask;
  logic wr_global;
  logic wr_polarity;

  // address decode of writes
  assign wr_enable = i_bus.wr && (i_bus.addr == ADDR_ENABLE);
  assign wr_direction = i_bus.wr && (i_bus.addr == ADDR_DIRECTION);
  assign wr_value = i_bus.wr && (i_bus.addr == ADDR_VALUE);
  assign wr_rise_flags = i_bus.wr && (i_bus.addr == ADDR_RISE_FLAGS);
  assign wr_rise_mask = i_bus.wr && (i_bus.addr == ADDR_RISE_MASK);
  assign wr_fall_flags = i_bus.wr && (i_bus.addr == ADDR_FALL_FLAGS);
  assign wr_fall_mask = i_bus.wr && (i_bus.addr == ADDR_FALL_MASK);
  assign wr_global = i_bus.wr && (i_bus.addr == ADDR_GLOBAL_CTRL);
  assign wr_polarity = i_bus.wr && (i_bus.addr == ADDR_POLARITY);

  // pins driven only when enabled and set as output
  assign drive = st.enable & st.direction;

  // edge watch only on enabled inputs
  assign watch = st.enable & ~st.direction;

  // polarity bit 1 turns the active sense round
  assign sense = st.sync2 ^ st.polarity;

  assign rise_hit = watch & sense & ~st.prev;
  assign fall_hit = watch & ~sense & st.prev;

  assign masked = (st.rise_flags & st.rise_mask) | (st.fall_flags & st.fall_mask);
  assign selected = st.rise_mask | st.fall_mask;

  // outputs read back the written value, others the synced level
  assign value_view = (st.value & drive) | (st.sync2 & ~drive);

  // event modes
  assign ev_any = |masked;
  assign ev_all = (selected != 16'h0000) && ((masked & selected) == selected);
  assign ev_level = |(sense & watch & selected);

  always_comb begin
    unique case (st.mode)
      GPP_MODE_OFF: begin
        ev_next = 1'b0;
      end
      GPP_MODE_ANY: begin
        ev_next = ev_any;
      end
      GPP_MODE_ALL: begin
        ev_next = ev_all;
      end
      GPP_MODE_LEVEL: begin
        ev_next = ev_level;
      end
    endcase
  end

  always_comb begin
    nx = st;

    // two stage synchroniser, then previous sense for edges
    nx.sync1 = i_pin_in;
    nx.sync2 = st.sync1;
    nx.prev = sense;

    if (wr_enable) begin
      nx.enable = i_bus.wdata[15:0];
    end
    if (wr_direction) begin
      nx.direction = i_bus.wdata[15:0];
    end
    if (wr_value) begin
      nx.value = i_bus.wdata[15:0];
    end
    if (wr_rise_mask) begin
      nx.rise_mask = i_bus.wdata[15:0];
    end
    if (wr_fall_mask) begin
      nx.fall_mask = i_bus.wdata[15:0];
    end
    if (wr_global) begin
      nx.mode = gpp_mode_t'(i_bus.wdata[GC_MODE_LSB +: 2]);
    end
    if (wr_polarity) begin
      nx.polarity = i_bus.wdata[15:0];
    end

    // write one clears; a new edge in the same cycle wins
    if (wr_rise_flags) begin
      nx.rise_flags = st.rise_flags & ~i_bus.wdata[15:0];
    end
    nx.rise_flags = nx.rise_flags | rise_hit;
    if (wr_fall_flags) begin
      nx.fall_flags = st.fall_flags & ~i_bus.wdata[15:0];
    end
    nx.fall_flags = nx.fall_flags | fall_hit;

    nx.event_lvl = ev_next;
    nx.dma_pulse = ev_next & ~st.event_lvl;

    // read data stands one cycle, zero otherwise
    nx.rdata = RDATA_IDLE;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_ENABLE: begin
          nx.rdata = {16'h0000, st.enable};
        end
        ADDR_DIRECTION: begin
          nx.rdata = {16'h0000, st.direction};
        end
        ADDR_VALUE: begin
          nx.rdata = {16'h0000, value_view};
        end
        ADDR_RISE_FLAGS: begin
          nx.rdata = {16'h0000, st.rise_flags};
        end
        ADDR_RISE_MASK: begin
          nx.rdata = {16'h0000, st.rise_mask};
        end
        ADDR_FALL_FLAGS: begin
          nx.rdata = {16'h0000, st.fall_flags};
        end
        ADDR_FALL_MASK: begin
          nx.rdata = {16'h0000, st.fall_mask};
        end
        ADDR_GLOBAL_CTRL: begin
          nx.rdata = {30'h0000_0000, st.mode};
        end
        ADDR_POLARITY: begin
          nx.rdata = {16'h0000, st.polarity};
        end
        default: begin
          nx.rdata = RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= RST_STATE;
    end else begin
      st <= nx;
    end
  end

  assign o_rdata = st.rdata;
  assign o_pad.level = st.value;
  assign o_pad.oe_n = ~drive;
  assign o_pad.owned = st.enable;
  assign o_evt.cpu_interrupt = st.event_lvl;
  assign o_evt.dma_event_request = st.dma_pulse;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  // disabled pins are never driven
  property p_disabled_float;
    ((~st.enable) & ~o_pad.oe_n) == 16'h0000;
  endproperty
  a_disabled_float: assert property (p_disabled_float)
    else $error("disabled pin driven");

  // enabled inputs are never driven
  property p_input_float;
    ((st.enable & ~st.direction) & ~o_pad.oe_n) == 16'h0000;
  endproperty
  a_input_float: assert property (p_input_float)
    else $error("input pin driven");

  // a direction write turns on drive for enabled pins next cycle
  property p_dir_write;
    (wr_direction && !wr_enable) |=>
      (~o_pad.oe_n) == ($past(st.enable) & $past(i_bus.wdata[15:0]));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not set drive");

  // output level follows the value write
  property p_value_drive;
    wr_value |=> o_pad.level == $past(i_bus.wdata[15:0]);
  endproperty
  a_value_drive: assert property (p_value_drive)
    else $error("output level not the written value");

  // stable input pins read back through the value register
  sequence s_pins_steady;
    $stable(i_pin_in) [*3];
  endsequence
  sequence s_value_read;
    i_bus.rd && (i_bus.addr == ADDR_VALUE);
  endsequence
  property p_value_read;
    (s_pins_steady ##0 s_value_read) |=>
      ((o_rdata[15:0] ^ $past(i_pin_in)) & ~$past(drive)) == 16'h0000;
  endproperty
  a_value_read: assert property (p_value_read)
    else $error("input level not seen in value read");

  // the reserved word reads as zero, one cycle after the strobe
  property p_reserved_read;
    (i_bus.rd && (i_bus.addr == ADDR_RESERVED)) |=> o_rdata == RDATA_IDLE;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved word read nonzero");

  // read data lasts only one cycle
  property p_rdata_one;
    !i_bus.rd |=> o_rdata == RDATA_IDLE;
  endproperty
  a_rdata_one: assert property (p_rdata_one)
    else $error("read data held beyond one cycle");

  // a rising edge sets its flag even against a clear
  property p_rise_set;
    (rise_hit != 16'h0000) |=> (st.rise_flags & $past(rise_hit)) == $past(rise_hit);
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rise flag not set");

  // a falling edge sets its flag even against a clear
  property p_fall_set;
    (fall_hit != 16'h0000) |=> (st.fall_flags & $past(fall_hit)) == $past(fall_hit);
  endproperty
  a_fall_set: assert property (p_fall_set)
    else $error("fall flag not set");

  // rise flags stay set without a flag write
  property p_rise_sticky;
    !wr_rise_flags |=> (st.rise_flags & $past(st.rise_flags)) == $past(st.rise_flags);
  endproperty
  a_rise_sticky: assert property (p_rise_sticky)
    else $error("rise flag lost without clear");

  // polarity 1 makes a falling pin a rising sense
  property p_polarity;
    (st.polarity[0] && $past(st.polarity[0]) && watch[0] && $past(watch[0]) &&
      $fell(st.sync2[0])) |-> rise_hit[0];
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("inverted polarity edge not detected");

  // unmasked flag in any mode raises the interrupt next cycle
  property p_any_mode;
    (st.mode == GPP_MODE_ANY && ev_any) |=> o_evt.cpu_interrupt;
  endproperty
  a_any_mode: assert property (p_any_mode)
    else $error("interrupt missing in any mode");

  // off mode keeps the interrupt low
  property p_off_mode;
    (st.mode == GPP_MODE_OFF) |=> !o_evt.cpu_interrupt;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("interrupt raised in off mode");

  // each rising interrupt carries one single cycle DMA pulse
  sequence s_dma_once;
    o_evt.dma_event_request ##1 !o_evt.dma_event_request;
  endsequence
  property p_dma_pulse;
    $rose(o_evt.cpu_interrupt) |-> s_dma_once;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse)
    else $error("dma event not a single pulse");

  // a pin reaches the second synchroniser stage after two edges
  property p_sync_delay;
    1'b1 |-> ##2 st.sync2 == $past(i_pin_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser delay wrong");

  // fall flags stay set without a flag write
  property p_fall_sticky;
    !wr_fall_flags |=> (st.fall_flags & $past(st.fall_flags)) == $past(st.fall_flags);
  endproperty
  a_fall_sticky: assert property (p_fall_sticky)
    else $error("fall flag lost without clear");

  // writing ones clears rise flags when no edge competes
  property p_rise_clear;
    (wr_rise_flags && rise_hit == 16'h0000) |=>
      (st.rise_flags & $past(i_bus.wdata[15:0])) == 16'h0000;
  endproperty
  a_rise_clear: assert property (p_rise_clear)
    else $error("rise flag not cleared");

  // writing ones clears fall flags when no edge competes
  property p_fall_clear;
    (wr_fall_flags && fall_hit == 16'h0000) |=>
      (st.fall_flags & $past(i_bus.wdata[15:0])) == 16'h0000;
  endproperty
  a_fall_clear: assert property (p_fall_clear)
    else $error("fall flag not cleared");

  // an enable write hands the pins to the port next cycle
  property p_enable_write;
    wr_enable |=> o_pad.owned == $past(i_bus.wdata[15:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write not applied");

  // only the mode field of global control reads back
  property p_mode_read;
    (i_bus.rd && (i_bus.addr == ADDR_GLOBAL_CTRL)) |=>
      o_rdata == {30'h0000_0000, $past(st.mode)};
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("global control read wrong");

  // all mode stays quiet while a selected pin lacks its flag
  property p_all_mode;
    (st.mode == GPP_MODE_ALL && (masked & selected) != selected) |=> !o_evt.cpu_interrupt;
  endproperty
  a_all_mode: assert property (p_all_mode)
    else $error("interrupt raised in all mode too early");

  // level mode follows the sensed level of a selected input
  property p_level_mode;
    (st.mode == GPP_MODE_LEVEL && watch[0] && st.rise_mask[0] &&
      (st.sync2[0] != st.polarity[0])) |=> o_evt.cpu_interrupt;
  endproperty
  a_level_mode: assert property (p_level_mode)
    else $error("interrupt missing in level mode");

  // no dma event without a fresh interrupt
  property p_dma_cause;
    o_evt.dma_event_request |-> $rose(o_evt.cpu_interrupt);
  endproperty
  a_dma_cause: assert property (p_dma_cause)
    else $error("dma event without rising interrupt");

endmodule : gpp_port

// ===== test/gpp_pin_partner.sv
// Purpose: external devices wired to the sixteen general pins
// Assumes: far side drives every pin the port leaves undriven
// Notes: a pin the port drives shows the port level to both sides
`timescale 1ns/1ps
module gpp_pin_partner (
  input wire gpp_pkg::gpp_pad_t i_pad,
  input wire gpp_pkg::gpp_pins_t i_ext,
  output gpp_pkg::gpp_pins_t o_pin
);
  import gpp_pkg::*;
  // external driver yields where the port drives
  assign o_pin = (~i_pad.oe_n & i_pad.level) | (i_pad.oe_n & i_ext);
endmodule : gpp_pin_partner

// ===== test/general_purpose_pin_port_tb_top.sv
// Purpose: self-checking bench of the general purpose pin port
// Assumes: partner drives every pin the port leaves undriven
// Notes: random data from a bench lfsr, corner cases by hand
`timescale 1ns/1ps
module general_purpose_pin_port_tb_top;
  import gpp_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  gpp_bus_req_t bus = '0;
  gpp_pins_t ext = 16'h0000;
  gpp_pins_t pin_in, en, dir, val;
  gpp_pad_t pad;
  gpp_event_t evt;
  logic [31:0] rdata;
  logic [31:0] lfsr = 32'h42B95724;
  int failures = 0;
  int cmp_count = 0;
  int dma_cnt = 0;
  logic [31:0] all_addr [11] = '{ADDR_ENABLE, ADDR_DIRECTION, ADDR_VALUE, ADDR_RESERVED,
    ADDR_RISE_FLAGS, ADDR_RISE_MASK, ADDR_FALL_FLAGS, ADDR_FALL_MASK, ADDR_GLOBAL_CTRL,
    ADDR_POLARITY, 32'h01B0_0028};
  logic [31:0] rw_addr [6] = '{ADDR_ENABLE, ADDR_DIRECTION, ADDR_RISE_MASK,
    ADDR_FALL_MASK, ADDR_GLOBAL_CTRL, ADDR_POLARITY};

  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (evt.dma_event_request === 1'b1) dma_cnt++;

  gpp_port dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
    .i_pin_in(pin_in), .o_pad(pad), .o_evt(evt));
  gpp_pin_partner partner (.i_pad(pad), .i_ext(ext), .o_pin(pin_in));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic [31:0] d);
    return (a == ADDR_GLOBAL_CTRL) ? {30'h0, d[1:0]} : {16'h0, d[15:0]};
  endfunction : exp_rd

  // driven pins read back the register, the rest read the wire
  function automatic gpp_pins_t exp_value(input gpp_pins_t e, input gpp_pins_t d,
      input gpp_pins_t v, input gpp_pins_t x);
    return (e & d & v) | (~(e & d) & x);
  endfunction : exp_value

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask : chk_word

  task automatic chk_pins(input gpp_pins_t g, input gpp_pins_t x, input string m);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask : chk_pins

  task automatic chk_bit(input logic g, input logic x, input string m);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: %s got %b expected %b", $time, m, g, x);
    end
  endtask : chk_bit

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] x, input string m);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1;
    chk_word(rdata, x, m);
  endtask : rdchk

  task automatic set_ext(input gpp_pins_t v);
    @(posedge i_mclk);
    ext <= v;
  endtask : set_ext

  // set up one pin scenario, clear flags, then move the pins
  task automatic edge_case(input gpp_pins_t pol, input gpp_pins_t rm, input gpp_pins_t fm,
      input logic [1:0] mode, input gpp_pins_t from, input gpp_pins_t to,
      input gpp_pins_t er, input gpp_pins_t ef, input logic irq);
    int c0;
    set_ext(from);
    wr(ADDR_ENABLE, {16'h0, en});
    wr(ADDR_DIRECTION, 32'h0);
    wr(ADDR_POLARITY, {16'h0, pol});
    wr(ADDR_RISE_MASK, {16'h0, rm});
    wr(ADDR_FALL_MASK, {16'h0, fm});
    wr(ADDR_GLOBAL_CTRL, {30'h0, mode});
    wr(ADDR_RISE_FLAGS, 32'h0000_FFFF);
    wr(ADDR_FALL_FLAGS, 32'h0000_FFFF);
    #1;
    c0 = dma_cnt;
    set_ext(to);
    repeat (6) @(posedge i_mclk);
    #1;
    chk_bit(evt.cpu_interrupt, irq, "interrupt");
    chk_word(32'(dma_cnt - c0), {31'h0, irq}, "dma pulses");
    rdchk(ADDR_RISE_FLAGS, {16'h0, er}, "rise flags");
    rdchk(ADDR_FALL_FLAGS, {16'h0, ef}, "fall flags");
  endtask : edge_case

  initial begin
    #(4000 * 50);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    #1;
    chk_pins(pad.oe_n, 16'hFFFF, "oe_n after reset");
    foreach (all_addr[i]) rdchk(all_addr[i], 32'h0, "reset read");
    foreach (rw_addr[i]) begin
      lfsr = lfsr_next(lfsr);
      wr(rw_addr[i], lfsr);
      rdchk(rw_addr[i], exp_rd(rw_addr[i], lfsr), "read back");
    end
    wr(ADDR_RESERVED, 32'hFFFF_FFFF);
    wr(32'h01B0_0028, 32'hFFFF_FFFF);
    rdchk(ADDR_RESERVED, 32'h0, "reserved read");
    rdchk(32'h01B0_0028, 32'h0, "unmapped read");
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      en = lfsr[15:0];
      dir = lfsr[31:16];
      lfsr = lfsr_next(lfsr);
      val = lfsr[15:0];
      set_ext(lfsr[31:16]);
      wr(ADDR_ENABLE, {16'h0, en});
      wr(ADDR_DIRECTION, {16'h0, dir});
      wr(ADDR_VALUE, {16'h0, val});
      #1;
      chk_pins(pad.owned, en, "owned");
      chk_pins(pad.oe_n, ~(en & dir), "oe_n");
      chk_pins(pad.level, val, "level");
      rdchk(ADDR_VALUE, {16'h0, exp_value(en, dir, val, ext)}, "value");
    end
    en = 16'hFFFF;
    edge_case(16'h0, 16'h1, 16'h0, 2'b01, 16'h0, 16'h1, 16'h1, 16'h0, 1'b1);
    wr(ADDR_RISE_FLAGS, 32'h0);
    rdchk(ADDR_RISE_FLAGS, 32'h1, "flag kept");
    wr(ADDR_RISE_FLAGS, 32'h1);
    repeat (2) @(posedge i_mclk);
    #1;
    chk_bit(evt.cpu_interrupt, 1'b0, "irq after clear");
    edge_case(16'h0, 16'h0, 16'h1, 2'b01, 16'h1, 16'h0, 16'h0, 16'h1, 1'b1);
    edge_case(16'h0, 16'h1, 16'h0, 2'b00, 16'h0, 16'h1, 16'h1, 16'h0, 1'b0);
    edge_case(16'h1, 16'h0, 16'h1, 2'b01, 16'h0, 16'h1, 16'h0, 16'h1, 1'b1);
    edge_case(16'h0, 16'h3, 16'h0, 2'b10, 16'h0, 16'h1, 16'h1, 16'h0, 1'b0);
    edge_case(16'h0, 16'h3, 16'h0, 2'b10, 16'h0, 16'h3, 16'h3, 16'h0, 1'b1);
    edge_case(16'h0, 16'h1, 16'h0, 2'b11, 16'h0, 16'h1, 16'h1, 16'h0, 1'b1);
    en = 16'hFFFE;
    edge_case(16'h0, 16'h1, 16'h0, 2'b01, 16'h0, 16'h1, 16'h0, 16'h0, 1'b0);
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk_pins(pad.oe_n, 16'hFFFF, "oe_n in reset");
    chk_bit(evt.cpu_interrupt, 1'b0, "irq in reset");
    @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rdchk(ADDR_DIRECTION, 32'h0, "direction after reset");
    print_verdict();
  end
endmodule : general_purpose_pin_port_tb_top
